// [smw_ctrl.sv]
`timescale 1ns/1ns
`default_nettype none
module smw_ctrl
    import smw_pkg::*;
(
    // clock, reset, enable
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // access request
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [CSW-1:0] req_cs,
    output logic req_ready,
    output logic done,
    // per-access configuration of the selected chip select
    input wire logic [TW-1:0] rd_strobe_setup,
    input wire logic [TW-1:0] rd_strobe_pulse,
    input wire logic [TW-1:0] cs_read_setup,
    input wire logic [TW-1:0] cs_read_pulse,
    input wire logic [TW-1:0] read_cycle_len,
    input wire logic [TW-1:0] wr_strobe_setup,
    input wire logic [TW-1:0] wr_strobe_pulse,
    input wire logic [TW-1:0] cs_write_setup,
    input wire logic [TW-1:0] cs_write_pulse,
    input wire logic [TW-1:0] write_cycle_len,
    input wire logic read_by_strobe,
    input wire logic write_by_strobe,
    input wire logic [1:0] ext_wait_select,
    input wire logic float_opt_en,
    input wire logic [FW-1:0] float_cycles,
    // power management
    input wire logic slow_clock,
    // memory pins
    input wire logic ext_wait_n,
    output logic [NUM_CS-1:0] chip_sel_n,
    output logic read_strobe_n,
    output logic write_strobe_n,
    // status
    output logic suspended
);
    // ------------------------------------------------------------
    // timing parameters and state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [TW-1:0] s_setup;
        logic [TW-1:0] s_pulse;
        logic [TW-1:0] c_setup;
        logic [TW-1:0] c_pulse;
        logic [TW-1:0] cycle;
    } smw_tim_t;

    typedef struct packed {
        smw_state_t st;
        logic wr;
        logic by_strobe;
        logic [1:0] wmode;
        logic [CSW-1:0] cs;
        smw_tim_t tim;
        logic [TW-1:0] cnt;
        logic [FW-1:0] fcnt;
        logic slow_seen;
        logic [NUM_CS-1:0] cs_n;
        logic rd_n;
        logic wr_n;
        logic rdy;
        logic done;
        logic susp;
    } smw_regs_t;

    smw_regs_t r_reg, r_next;
    logic wait_sync_n;

    smw_wait_sync u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .ext_wait_n(ext_wait_n),
        .wait_sync_n(wait_sync_n)
    );

    // strobe is low while count lies in [setup, setup+pulse)
    function automatic logic in_pulse(input logic [TW-1:0] c, input logic [TW-1:0] s,
                                      input logic [TW-1:0] p);
        in_pulse = (c >= s) && (c < s + p);
    endfunction : in_pulse

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    logic ctl_pulse;
    logic ctl_last;
    logic [TW-1:0] ctl_end;
    logic [TW-1:0] hold_len;
    logic [FW-1:0] float_left;
    always_comb begin
        r_next = r_reg;
        r_next.done = 1'b0;
        ctl_end = r_reg.by_strobe ? r_reg.tim.s_setup + r_reg.tim.s_pulse
                                  : r_reg.tim.c_setup + r_reg.tim.c_pulse;
        ctl_pulse = r_reg.by_strobe ? in_pulse(r_reg.cnt, r_reg.tim.s_setup, r_reg.tim.s_pulse)
                                    : in_pulse(r_reg.cnt, r_reg.tim.c_setup, r_reg.tim.c_pulse);
        ctl_last = ctl_pulse && (r_reg.cnt + ONE == ctl_end);
        hold_len = r_reg.tim.cycle - ctl_end;
        float_left = (hold_len >= {2'h0, float_cycles}) ? FZERO
                   : FW'(float_cycles - hold_len[FW-1:0]);
        unique case (r_reg.st)
            ST_IDLE: begin
                if (slow_clock != r_reg.slow_seen) begin
                    r_next.st = ST_RELOAD;
                    r_next.rdy = 1'b0;
                end else if (req_valid && r_reg.rdy) begin
                    r_next.rdy = 1'b0;
                    r_next.wr = req_write;
                    r_next.cs = req_cs;
                    r_next.cnt = ZERO;
                    r_next.st = ST_RUN;
                    if (slow_clock) begin
                        // the same built-in set for every chip select
                        r_next.wmode = WAIT_OFF;
                        r_next.by_strobe = 1'b1;
                        r_next.tim = req_write
                            ? '{SC_WR_SETUP, SC_WR_PULSE, SC_CS_WR_SETUP, SC_CS_WR_PULSE,
                                SC_WR_CYCLE}
                            : '{SC_RD_SETUP, SC_RD_PULSE, SC_CS_RD_SETUP, SC_CS_RD_PULSE,
                                SC_RD_CYCLE};
                    end else begin
                        r_next.wmode = ext_wait_select;
                        r_next.by_strobe = req_write ? write_by_strobe : read_by_strobe;
                        r_next.tim = req_write
                            ? '{wr_strobe_setup, wr_strobe_pulse, cs_write_setup,
                                cs_write_pulse, write_cycle_len}
                            : '{rd_strobe_setup, rd_strobe_pulse, cs_read_setup,
                                cs_read_pulse, read_cycle_len};
                    end
                end
            end
            ST_RUN: begin
                if (r_reg.wmode == WAIT_FROZEN && ctl_pulse && !wait_sync_n) begin
                    r_next.susp = 1'b1;
                end else if (r_reg.wmode == WAIT_READY && ctl_last && !wait_sync_n) begin
                    r_next.st = ST_SUSP;
                    r_next.susp = 1'b1;
                end else begin
                    r_next.susp = 1'b0;
                    r_next.cnt = r_reg.cnt + ONE;
                    if (r_reg.cnt + ONE >= r_reg.tim.cycle) begin
                        r_next.done = 1'b1;
                        if (!r_reg.wr && !float_opt_en && float_left != FZERO) begin
                            r_next.fcnt = float_left;
                            r_next.st = ST_FLOAT;
                        end else begin
                            r_next.st = ST_IDLE;
                            r_next.rdy = 1'b1;
                        end
                    end
                end
            end
            ST_SUSP: begin
                if (wait_sync_n) begin
                    r_next.susp = 1'b0;
                    r_next.cnt = r_reg.cnt + ONE;
                    r_next.st = ST_RUN;
                end
            end
            ST_FLOAT: begin
                r_next.fcnt = r_reg.fcnt - 4'h1;
                if (r_reg.fcnt == 4'h1) begin
                    r_next.st = ST_IDLE;
                    r_next.rdy = 1'b1;
                end
            end
            ST_RELOAD: begin
                r_next.slow_seen = slow_clock;
                r_next.st = ST_IDLE;
                r_next.rdy = 1'b1;
            end
        endcase
        // pin levels follow the counter; frozen state keeps them unchanged
        r_next.cs_n = '1;
        r_next.rd_n = 1'b1;
        r_next.wr_n = 1'b1;
        if (r_next.st == ST_RUN || r_next.st == ST_SUSP) begin
            r_next.cs_n[r_next.cs] = !in_pulse(r_next.cnt, r_next.tim.c_setup,
                                               r_next.tim.c_pulse);
            if (r_next.wr) begin
                r_next.wr_n = !in_pulse(r_next.cnt, r_next.tim.s_setup, r_next.tim.s_pulse);
            end else begin
                r_next.rd_n = !in_pulse(r_next.cnt, r_next.tim.s_setup, r_next.tim.s_pulse);
            end
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            r_reg <= '{st: ST_IDLE, cs_n: '1, rd_n: 1'b1, wr_n: 1'b1, rdy: 1'b1,
                       default: '0};
        end else if (ce) begin
            r_reg <= r_next;
        end
    end

    assign req_ready = r_reg.rdy;
    assign done = r_reg.done;
    assign chip_sel_n = r_reg.cs_n;
    assign read_strobe_n = r_reg.rd_n;
    assign write_strobe_n = r_reg.wr_n;
    assign suspended = r_reg.susp;
endmodule : smw_ctrl
`default_nettype wire

// [smw_pkg.sv]
package smw_pkg;
    localparam int NUM_CS = 8;
    localparam int CSW = 3;
    localparam int TW = 6;
    localparam int FW = 4;
    localparam logic [1:0] WAIT_OFF = 2'h0;
    localparam logic [1:0] WAIT_FROZEN = 2'h2;
    localparam logic [1:0] WAIT_READY = 2'h3;
    localparam int SYNC_STAGES = 2;
    localparam logic [TW-1:0] SC_RD_SETUP = 6'h01;
    localparam logic [TW-1:0] SC_RD_PULSE = 6'h01;
    localparam logic [TW-1:0] SC_CS_RD_SETUP = 6'h00;
    localparam logic [TW-1:0] SC_CS_RD_PULSE = 6'h02;
    localparam logic [TW-1:0] SC_RD_CYCLE = 6'h02;
    localparam logic [TW-1:0] SC_WR_SETUP = 6'h01;
    localparam logic [TW-1:0] SC_WR_PULSE = 6'h01;
    localparam logic [TW-1:0] SC_CS_WR_SETUP = 6'h00;
    localparam logic [TW-1:0] SC_CS_WR_PULSE = 6'h03;
    localparam logic [TW-1:0] SC_WR_CYCLE = 6'h03;
    localparam logic [TW-1:0] ONE = 6'h01;
    localparam logic [TW-1:0] ZERO = 6'h00;
    localparam logic [FW-1:0] FZERO = 4'h0;
    typedef enum logic [2:0] {ST_IDLE, ST_RUN, ST_SUSP, ST_FLOAT, ST_RELOAD} smw_state_t;
endpackage : smw_pkg

// [smw_wait_sync.sv]
`timescale 1ns/1ns
`default_nettype none
module smw_wait_sync
    import smw_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // wait pin and synchronised level
    input wire logic ext_wait_n,
    output logic wait_sync_n
);
    typedef struct packed {
        logic [SYNC_STAGES-1:0] stage;
    } smw_sync_t;
    smw_sync_t s_reg, s_next;
    always_comb begin
        s_next = s_reg;
        s_next.stage = {s_reg.stage[SYNC_STAGES-2:0], ext_wait_n};
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_reg <= '1;
        end else if (ce) begin
            s_reg <= s_next;
        end
    end
    assign wait_sync_n = s_reg.stage[SYNC_STAGES-1];
endmodule : smw_wait_sync
`default_nettype wire

// [smw_ctrl_sva.sv]
`timescale 1ns/1ns
`default_nettype none
module smw_ctrl_sva
    import smw_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // watched ports
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic req_ready,
    input wire logic done,
    input wire logic [1:0] ext_wait_select,
    input wire logic slow_clock,
    input wire logic ext_wait_n,
    input wire logic [NUM_CS-1:0] chip_sel_n,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic suspended
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire acc = req_valid && req_ready && slow_clock;
    wire cs = !(&chip_sel_n);
    sequence s_rd;
        read_strobe_n && cs ##1 !read_strobe_n ##1 done && read_strobe_n && !cs;
    endsequence
    sequence s_wr;
        write_strobe_n && cs ##1 !write_strobe_n ##1 write_strobe_n && cs ##1 done && !cs;
    endsequence
    property p_slow_rd; acc && !req_write |=> s_rd; endproperty
    a_slow_rd: assert property (p_slow_rd) else $error("slow read shape");
    property p_slow_wr; acc && req_write |=> s_wr; endproperty
    a_slow_wr: assert property (p_slow_wr) else $error("slow write shape");
    property p_ignore; !ext_wait_select[1] || slow_clock |-> !suspended; endproperty
    a_ignore: assert property (p_ignore) else $error("wait not ignored");
    property p_pulse; $rose(suspended) |-> cs; endproperty
    a_pulse: assert property (p_pulse) else $error("suspend outside access");
    property p_sync; $rose(suspended) |-> !$past(ext_wait_n, 3); endproperty
    a_sync: assert property (p_sync) else $error("wait not synchronised");
    property p_release; suspended && $rose(ext_wait_n) |=> suspended; endproperty
    a_release: assert property (p_release) else $error("release too early");
    property p_hold;
        suspended && $past(suspended) |-> $stable({chip_sel_n, read_strobe_n, write_strobe_n});
    endproperty
    a_hold: assert property (p_hold) else $error("pins moved while held");
    property p_ready;
        $fell(suspended) && ext_wait_select == WAIT_READY |-> ##[1:63] done;
    endproperty
    a_ready: assert property (p_ready) else $error("no finish after ready");
endmodule : smw_ctrl_sva
bind smw_ctrl smw_ctrl_sva u_sva (.clk, .rst_n, .req_valid, .req_write, .req_ready, .done,
    .ext_wait_select, .slow_clock, .ext_wait_n, .chip_sel_n, .read_strobe_n,
    .write_strobe_n, .suspended);
`default_nettype wire

// [smw_mem_model.sv]
`timescale 1ns/1ns
`default_nettype none
module smw_mem_model
    import smw_pkg::*;
(
    // memory pins
    input wire logic clk,
    input wire logic [NUM_CS-1:0] chip_sel_n,
    // wait latency and length; zero length never waits
    input wire logic [7:0] lat,
    input wire logic [7:0] len,
    output logic ext_wait_n
);
    int t = 0;
    initial ext_wait_n = 1'b1;
    // wait answers the current request only; pulled up once released
    always @(posedge clk) begin
        t <= &chip_sel_n ? 0 : t + 1;
        ext_wait_n <= &chip_sel_n || len == 8'h00 || t < lat || t >= lat + len;
    end
endmodule : smw_mem_model
`default_nettype wire

// [smw_ctrl_test.sv]
`timescale 1ns/1ns
`default_nettype none
module smw_ctrl_test
    import smw_pkg::*;
;
    // write, slow, select, pulse, cycle, wait latency, wait length, cycles to done
    localparam int R[8][8] = '{'{0, 0, 0, 2, 4, 1, 3, 4}, '{1, 0, 0, 3, 6, 0, 0, 6},
        '{0, 0, 2, 10, 12, 1, 3, 15}, '{1, 0, 3, 5, 8, 1, 12, 19},
        '{0, 0, 3, 10, 12, 1, 2, 12}, '{0, 0, 3, 10, 12, 10, 3, 12},
        '{0, 1, 0, 2, 4, 1, 3, 2}, '{1, 1, 0, 2, 4, 1, 3, 3}};
    int pv = 2, cv = 4, n, f, bad_count = 0, n_compared = 0;
    logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, req_valid = 1'b0, req_write = 1'b0;
    logic read_by_strobe = 1'b1, write_by_strobe = 1'b1, float_opt_en = 1'b1, slow_clock = 1'b0;
    logic [CSW-1:0] req_cs = 3'h0;
    logic [1:0] ext_wait_select = 2'h0;
    logic [FW-1:0] float_cycles = 4'hf;
    logic [7:0] lat = 8'h00, len = 8'h00;
    logic req_ready, done, read_strobe_n, write_strobe_n, suspended;
    logic [NUM_CS-1:0] chip_sel_n;
    wire ext_wait_n;
    // every controlling strobe keeps a hold of one cycle or more
    wire [TW-1:0] rd_strobe_setup = ONE, wr_strobe_setup = ONE, cs_read_setup = ZERO;
    wire [TW-1:0] cs_write_setup = ZERO, rd_strobe_pulse = TW'(pv), wr_strobe_pulse = TW'(pv);
    wire [TW-1:0] cs_read_pulse = TW'(cv - 1), cs_write_pulse = TW'(cv - 1);
    wire [TW-1:0] read_cycle_len = TW'(cv), write_cycle_len = TW'(cv);
    smw_ctrl uut (.clk, .rst_n, .ce, .req_valid, .req_write, .req_cs, .req_ready, .done,
        .rd_strobe_setup, .rd_strobe_pulse, .cs_read_setup, .cs_read_pulse, .read_cycle_len,
        .wr_strobe_setup, .wr_strobe_pulse, .cs_write_setup, .cs_write_pulse, .write_cycle_len,
        .read_by_strobe, .write_by_strobe, .ext_wait_select, .float_opt_en, .float_cycles,
        .slow_clock, .ext_wait_n, .chip_sel_n, .read_strobe_n, .write_strobe_n, .suspended);
    smw_mem_model u_mem (.clk, .chip_sel_n, .lat, .len, .ext_wait_n);
    always #5 clk = ~clk;
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR at %0t: got %0h want %0h", $time, seen, exp);
        end
    endtask : chk
    task automatic print_verdict;
        $display("compared %0d, mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : print_verdict
    // n: cycles from accept to done, f: float cycles after done
    task automatic access(input logic w);
        req_write = w;
        repeat (2) @(posedge clk) #1;
        for (n = 0; req_ready !== 1'b1 && n < 99; n++) @(posedge clk) #1;
        req_valid = 1'b1;
        @(posedge clk) #1;
        req_valid = 1'b0;
        for (n = 0; done !== 1'b1 && n < 99; n++) @(posedge clk) #1;
        for (f = 0; req_ready !== 1'b1 && f < 99; f++) @(posedge clk) #1;
    endtask : access
    initial begin
        #50000;
        bad_count++;
        print_verdict;
    end
    initial begin
        repeat (12) @(posedge clk) #1;
        chk(16'({chip_sel_n, read_strobe_n, write_strobe_n, req_ready, done, suspended}),
            16'h1ffc);
        rst_n = 1'b1;
        $display("reset test done");
        for (int i = 0; i < 8; i++) begin
            {pv, cv} = {R[i][3], R[i][4]};
            {slow_clock, ext_wait_select} = {R[i][1][0], 2'(R[i][2])};
            {lat, len, req_cs} = {8'(R[i][5]), 8'(R[i][6]), 3'(i)};
            {read_by_strobe, write_by_strobe} = {2{i < 4}};
            access(R[i][0][0]);
            chk(16'(n), 16'(R[i][7]));
            chk(16'({chip_sel_n, read_strobe_n, write_strobe_n, suspended}), 16'h7fe);
            $display("row %0d done", i);
        end
        {slow_clock, ext_wait_select, len, float_opt_en} = {1'b0, WAIT_OFF, 8'h00, 1'b0};
        access(1'b1);
        chk(16'(f), 16'h0);
        access(1'b0);
        chk(16'(f), 16'he);
        float_cycles = 4'h1;
        access(1'b0);
        chk(16'(f), 16'h0);
        // reset in mid-access returns every pin to idle
        for (n = 0; req_ready !== 1'b1 && n < 99; n++) @(posedge clk) #1;
        req_valid = 1'b1;
        @(posedge clk) #1;
        req_valid = 1'b0;
        chk(16'(&chip_sel_n), 16'h0);
        @(posedge clk) #1;
        rst_n = 1'b0;
        @(posedge clk) #1;
        chk(16'({chip_sel_n, read_strobe_n, write_strobe_n, req_ready, done, suspended}),
            16'h1ffc);
        rst_n = 1'b1;
        access(1'b0);
        chk(16'(n), 16'(cv));
        $display("mid-run reset test done");
        // clock enable low for three edges stretches the access by three
        fork
            access(1'b0);
            begin
                @(negedge req_valid);
                @(posedge clk) #1;
                ce = 1'b0;
                repeat (3) @(posedge clk) #1;
                ce = 1'b1;
            end
        join
        chk(16'(n), 16'(cv + 3));
        $display("clock enable test done");
        slow_clock = 1'b1;
        for (f = 0; f < 3 && req_ready === 1'b1; f++) @(posedge clk) #1;
        chk(16'(f < 3), 16'h1);
        @(posedge clk) #1;
        chk(16'(req_ready), 16'h1);
        $display("float and reload tests done");
        print_verdict;
    end
endmodule : smw_ctrl_test
`default_nettype wire
